//--- rtl/sams_pkg.sv
// shared constants and carrier types for the serial converter sequencer
// assumes a single 100 MHz system clock; all link pins arrive asynchronously
package sams_pkg;
  localparam int SAMS_CLK_PERIOD_NS = 10; // system clock period
  localparam int SAMS_ON_DELAY_NS = 1000; // channel-on delay, plain default
  // least time: round up to whole cycles, never below one
  localparam int SAMS_ON_DELAY_CYC =
    (SAMS_ON_DELAY_NS + SAMS_CLK_PERIOD_NS - 1) / SAMS_CLK_PERIOD_NS;
  localparam int SAMS_RES_BITS = 12; // conversion length in link clocks
  localparam int SAMS_WORD_BITS = 4; // input word length
  localparam int SAMS_CHANNELS = 8; // widest multiplexer variant
  localparam logic [3:0] SAMS_MSB_IDX = 4'hB; // first trial bit
  localparam logic [3:0] SAMS_COPY_START = 4'h1; // copy shares the lsb
  localparam logic [3:0] SAMS_COPY_END = 4'hC; // one past the top bit
  localparam logic [4:0] SAMS_HOLD_FALL = 5'h01; // index of the 2nd fall
  localparam int SAMS_EN_POS = 3; // enable bit position in the word
  localparam int SAMS_ADDR_TOP = 2; // top address bit position
  localparam logic [11:0] SAMS_MSB_TRIAL = 12'h800; // first sar trial
  localparam logic [7:0] SAMS_ALL_OFF = 8'h00; // every channel open
  localparam logic [15:0] SAMS_CNT_W1 = 16'h0001; // counter terminal value
  localparam logic [15:0] SAMS_ON_CNT = 16'(SAMS_ON_DELAY_CYC);

  // raw pin levels, before or after the two-stage synchroniser
  typedef struct packed {
    logic sclk;
    logic mux_n;
    logic adc_n;
    logic din;
    logic comp;
    logic eight;
  } sams_pins_s;

  // one-cycle edge events found on the synchronised pins
  typedef struct packed {
    logic sclk_rise;
    logic sclk_fall;
    logic mux_fall;
    logic adc_fall;
  } sams_edges_s;

  typedef enum {
    SAMS_IDLE,
    SAMS_SAMPLE,
    SAMS_CONVERT,
    SAMS_SHIFT
  } sams_state_e;
endpackage

//--- rtl/sams_pin_sync.sv
// two-stage synchroniser for every link pin, edge finder for sclk and both selects
// assumes pins are asynchronous to sys_clk; selects idle high after reset
`timescale 1ns/100ps
`default_nettype none
module sams_pin_sync (
  input wire logic sys_clk,
  input wire logic rst,
  input wire sams_pkg::sams_pins_s pins_raw,
  output sams_pkg::sams_pins_s pins_sync,
  output sams_pkg::sams_edges_s edges
);
  import sams_pkg::*;

  localparam sams_pins_s PINS_IDLE = '{sclk: 1'b0, mux_n: 1'b1, adc_n: 1'b1,
                                       din: 1'b0, comp: 1'b0, eight: 1'b0};

  sams_pins_s meta_reg; // first stage, read only by the second stage
  sams_pins_s sync_reg; // second stage, safe to use
  sams_pins_s last_reg; // previous synced value for edge finding
  sams_pins_s meta_next;
  sams_pins_s sync_next;
  sams_pins_s last_next;

  // next values: plain shift through three stages
  always_comb begin
    meta_next = pins_raw;
    sync_next = meta_reg;
    last_next = sync_reg;
  end

  // registers only; selects reset high so no false falling edge appears
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= PINS_IDLE;
      sync_reg <= PINS_IDLE;
      last_reg <= PINS_IDLE;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end

  assign pins_sync = sync_reg;
  // edges compare second and third stages, never the first
  assign edges.sclk_rise = sync_reg.sclk & ~last_reg.sclk;
  assign edges.sclk_fall = ~sync_reg.sclk & last_reg.sclk;
  assign edges.mux_fall = ~sync_reg.mux_n & last_reg.mux_n;
  assign edges.adc_fall = ~sync_reg.adc_n & last_reg.adc_n;
endmodule
`default_nettype wire

//--- rtl/sams_top.sv
// digital sequencer of a multichannel 12-bit sampling converter
// assumes the host makes sclk (at most sys_clk/8) and both selects;
// the analog comparator reports input above dac code on comparator_high
//
// Contract
// - three bits after enable form channel address
// - conversion measured against negative common input
// - four-channel: enable low off, else low two; code turns all off when the top address bit is set
// - eight-channel: enable low off, else binary three
// - unipolar straight binary, zero volts all zeros
// - shared wire driven before sixth falling clock
// - mux and converter selects work independently
// - end of conversion powers down; lsb copy, zeros
// - select high: converter off, word still shifts
// - sample opens after on delay, closes 2nd fall
// - 2nd fall: hold, common input, twelve clocks
// - sample lasts at least one and half clocks
// - launch on falling clock, capture on rising
// - shift four bits on rising clock, keep last
// - first held bit is enable, then address
// - one null bit before the result
`timescale 1ns/100ps
`default_nettype none
module sams_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic mux_select_n,
  input wire logic converter_select_n,
  input wire logic data_in,
  input wire logic comparator_high,
  input wire logic eight_channel,
  output logic [7:0] channel_on,
  output logic sample_switch,
  output logic hold_to_common,
  output logic [11:0] dac_code,
  output logic converter_power,
  output logic reference_load,
  output logic data_out,
  output logic data_oe,
  output logic [11:0] result,
  output logic result_valid
);
  import sams_pkg::*;

  sams_pins_s pins_raw; // raw pin bundle
  sams_pins_s pins; // synchronised levels
  sams_edges_s edges; // one-cycle edge events

  // decode enable and address into one-hot channel switches
  function automatic logic [7:0] chan_decode(input logic [3:0] word,
                                             input logic eight);
    logic [7:0] hot;
    hot = SAMS_ALL_OFF;
    if (!word[SAMS_EN_POS]) begin
      hot = SAMS_ALL_OFF; // enable low: all off, address ignored
    end else if (eight) begin
      hot[word[2:0]] = 1'b1; // plain binary of three bits
    end else if (!word[SAMS_ADDR_TOP]) begin
      hot[word[2:0]] = 1'b1; // top bit zero picks 0..3
    end else begin
      hot = SAMS_ALL_OFF; // no such channel on the small variant
    end
    return hot;
  endfunction

  // down counter step shared by both on-delay timers
  function automatic logic [15:0] cnt_step(input logic [15:0] cnt);
    return (cnt > SAMS_CNT_W1) ? 16'(cnt - SAMS_CNT_W1) : SAMS_CNT_W1;
  endfunction

  assign pins_raw = '{sclk: sclk, mux_n: mux_select_n, adc_n: converter_select_n,
                      din: data_in, comp: comparator_high, eight: eight_channel};

  // every pin passes two flip-flops before logic reads it
  sams_pin_sync u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pins_raw(pins_raw),
    .pins_sync(pins),
    .edges(edges)
  );

  // multiplexer side state
  logic [3:0] word_reg; // channel word shift register
  logic [3:0] word_next;
  logic [7:0] chan_reg; // channel switches
  logic [7:0] chan_next;
  logic [15:0] mux_cnt_reg; // channel-on delay count
  logic [15:0] mux_cnt_next;
  logic mux_wait_reg; // break-before-make in progress
  logic mux_wait_next;

  // mux next state: shift while deselected, switch after on delay
  always_comb begin
    word_next = word_reg;
    chan_next = chan_reg;
    mux_cnt_next = mux_cnt_reg;
    mux_wait_next = mux_wait_reg;
    if (pins.mux_n && edges.sclk_rise) begin
      // capture on rising clock, newest bit enters the bottom
      word_next = {word_reg[2:0], pins.din};
    end
    if (edges.mux_fall) begin
      // all channels open first so two never touch, then wait
      chan_next = SAMS_ALL_OFF;
      mux_cnt_next = SAMS_ON_CNT;
      mux_wait_next = 1'b1;
    end else if (mux_wait_reg) begin
      mux_cnt_next = cnt_step(mux_cnt_reg);
      if (mux_cnt_reg == SAMS_CNT_W1) begin
        // oldest bit is enable, the next three are the address
        chan_next = chan_decode(word_reg, pins.eight);
        mux_wait_next = 1'b0;
      end
    end
  end

  // mux registers; channel stays on until the next select fall
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      word_reg <= 4'h0;
      chan_reg <= SAMS_ALL_OFF;
      mux_cnt_reg <= SAMS_CNT_W1;
      mux_wait_reg <= 1'b0;
    end else begin
      word_reg <= word_next;
      chan_reg <= chan_next;
      mux_cnt_reg <= mux_cnt_next;
      mux_wait_reg <= mux_wait_next;
    end
  end

  // converter side state
  sams_state_e state_reg; // converter phase
  sams_state_e state_next;
  logic [15:0] adc_cnt_reg; // sample window opening delay
  logic [15:0] adc_cnt_next;
  logic open_reg; // sample window open
  logic open_next;
  logic [4:0] fall_reg; // falling clocks seen while sampling
  logic [4:0] fall_next;
  logic [11:0] sar_reg; // successive approximation code
  logic [11:0] sar_next;
  logic [3:0] idx_reg; // trial bit, later copy index
  logic [3:0] idx_next;
  logic [11:0] res_reg; // finished result
  logic [11:0] res_next;
  logic valid_reg; // one-cycle result strobe
  logic valid_next;
  logic dout_reg; // serial output bit
  logic dout_next;
  logic oe_reg; // serial output drive
  logic oe_next;
  logic keep_bit; // comparator verdict for the trial bit
  logic [11:0] sar_kept; // code with the verdict applied

  // converter next state
  always_comb begin
    state_next = state_reg;
    adc_cnt_next = adc_cnt_reg;
    open_next = open_reg;
    fall_next = fall_reg;
    sar_next = sar_reg;
    idx_next = idx_reg;
    res_next = res_reg;
    valid_next = 1'b0;
    dout_next = dout_reg;
    oe_next = oe_reg;
    // input above dac keeps the bit: straight binary code
    keep_bit = pins.comp;
    sar_kept = keep_bit ? sar_reg : (sar_reg & ~(12'h001 << idx_reg));
    if (pins.adc_n) begin
      // deselected: converter fully off, wire released
      state_next = SAMS_IDLE;
      open_next = 1'b0;
      fall_next = 5'h00;
      dout_next = 1'b0;
      oe_next = 1'b0;
    end else begin
      case (state_reg)
        SAMS_IDLE: begin
          if (edges.adc_fall) begin
            state_next = SAMS_SAMPLE;
            adc_cnt_next = SAMS_ON_CNT;
            open_next = 1'b0;
            fall_next = 5'h00;
          end
        end
        SAMS_SAMPLE: begin
          if (!open_reg) begin
            adc_cnt_next = cnt_step(adc_cnt_reg);
            // window opens one on delay after the select fall
            open_next = (adc_cnt_reg == SAMS_CNT_W1);
          end
          if (edges.sclk_fall) begin
            fall_next = 5'(fall_reg + 5'h01);
            // first falling clock takes the wire, well before the sixth
            oe_next = 1'b1;
            dout_next = 1'b0;
            if (fall_reg == SAMS_HOLD_FALL) begin
              // second fall ends sampling after at least 1.5 clocks
              state_next = SAMS_CONVERT;
              open_next = 1'b0;
              sar_next = SAMS_MSB_TRIAL;
              idx_next = SAMS_MSB_IDX;
              dout_next = 1'b0; // null bit ahead of the result
            end
          end
        end
        SAMS_CONVERT: begin
          if (edges.sclk_fall) begin
            // decide one bit per link clock, launch it msb first
            dout_next = keep_bit; // launched on the falling clock
            if (idx_reg == 4'h0) begin
              state_next = SAMS_SHIFT;
              sar_next = sar_kept;
              res_next = sar_kept;
              valid_next = 1'b1;
              idx_next = SAMS_COPY_START;
            end else begin
              sar_next = sar_kept | (12'h001 << (idx_reg - 4'h1));
              idx_next = 4'(idx_reg - 4'h1);
            end
          end
        end
        SAMS_SHIFT: begin
          if (edges.sclk_fall) begin
            // powered down; lsb-first copy then zeros while clocked
            if (idx_reg < SAMS_COPY_END) begin
              dout_next = res_reg[idx_reg];
              idx_next = 4'(idx_reg + 4'h1);
            end else begin
              dout_next = 1'b0;
            end
          end
        end
        default: begin
          state_next = SAMS_IDLE;
        end
      endcase
    end
  end

  // converter registers; select high is the only reset the link gives
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= SAMS_IDLE;
      adc_cnt_reg <= SAMS_CNT_W1;
      open_reg <= 1'b0;
      fall_reg <= 5'h00;
      sar_reg <= 12'h000;
      idx_reg <= 4'h0;
      res_reg <= 12'h000;
      valid_reg <= 1'b0;
      dout_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      adc_cnt_reg <= adc_cnt_next;
      open_reg <= open_next;
      fall_reg <= fall_next;
      sar_reg <= sar_next;
      idx_reg <= idx_next;
      res_reg <= res_next;
      valid_reg <= valid_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
    end
  end

  // analog controls follow the registered phase
  assign channel_on = chan_reg;
  assign sample_switch = (state_reg == SAMS_SAMPLE) && open_reg;
  // sampling cap rests on the common input during conversion
  assign hold_to_common = (state_reg == SAMS_CONVERT);
  assign dac_code = sar_reg;
  // comparator, bias and reference load only while sampling or converting
  assign converter_power = (state_reg == SAMS_SAMPLE) || (state_reg == SAMS_CONVERT);
  assign reference_load = converter_power;
  assign data_out = dout_reg;
  assign data_oe = oe_reg;
  assign result = res_reg;
  assign result_valid = valid_reg;
endmodule
`default_nettype wire

//--- sim/sams_top_sva.sv
// checker of the converter sequencer, watching only the top ports
// assumes one sys_clk domain with async active-high rst; bound below
`timescale 1ns/100ps
`default_nettype none
module sams_top_sva
  import sams_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic mux_select_n,
  input wire logic converter_select_n,
  input wire logic eight_channel,
  input wire logic [7:0] channel_on,
  input wire logic sample_switch,
  input wire logic hold_to_common,
  input wire logic [11:0] dac_code,
  input wire logic converter_power,
  input wire logic reference_load,
  input wire logic data_oe,
  input wire logic result_valid
);
  logic sclk_d_reg; // raw sclk one cycle back
  logic sclk_d_next;
  logic [2:0] fall_cnt_reg; // raw falls since select went low
  logic [2:0] fall_cnt_next;
  logic [7:0] low_cnt_reg; // cycles with converter select low, saturating
  logic [7:0] low_cnt_next;
  logic [7:0] smpl_cnt_reg; // cycles with the sample switch closed this frame
  logic [7:0] smpl_cnt_next;
  // one and a half link clocks at the bench's 80 ns link period
  localparam int SMPL_MIN_CYC = 12;
  // next values of the helper counters
  always_comb begin
    sclk_d_next = sclk;
    fall_cnt_next = fall_cnt_reg;
    low_cnt_next = low_cnt_reg;
    smpl_cnt_next = smpl_cnt_reg;
    if (converter_select_n) begin
      fall_cnt_next = 3'h0;
    end else if (sclk_d_reg && !sclk && fall_cnt_reg != 3'h7) begin
      fall_cnt_next = fall_cnt_reg + 3'h1;
    end
    // the sample window is timed from the converter select, not the mux one
    if (converter_select_n) begin
      low_cnt_next = 8'h00;
    end else if (low_cnt_reg != 8'hFF) begin
      low_cnt_next = low_cnt_reg + 8'h01;
    end
    if (converter_select_n) begin
      smpl_cnt_next = 8'h00;
    end else if (sample_switch && smpl_cnt_reg != 8'hFF) begin
      smpl_cnt_next = smpl_cnt_reg + 8'h01;
    end
  end
  // register the helpers; saturation avoids a wrap on long holds
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sclk_d_reg <= 1'b0;
      fall_cnt_reg <= 3'h0;
      low_cnt_reg <= 8'h00;
      smpl_cnt_reg <= 8'h00;
    end else begin
      sclk_d_reg <= sclk_d_next;
      fall_cnt_reg <= fall_cnt_next;
      low_cnt_reg <= low_cnt_next;
      smpl_cnt_reg <= smpl_cnt_next;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_drive_by_sixth;
    (sclk_d_reg && !sclk && fall_cnt_reg == 3'h5 && !converter_select_n) |-> data_oe;
  endproperty
  a_drive_by_sixth: assert property (p_drive_by_sixth)
    else $error("wire not driven at sixth fall");
  property p_off_when_high;
    converter_select_n [*6] |-> !converter_power && !data_oe && !hold_to_common;
  endproperty
  a_off_when_high: assert property (p_off_when_high)
    else $error("converter active with select high");
  property p_one_channel;
    $onehot0(channel_on);
  endproperty
  a_one_channel: assert property (p_one_channel)
    else $error("more than one channel on");
  property p_four_upper_off;
    !eight_channel |-> channel_on[7:4] == 4'h0;
  endproperty
  a_four_upper_off: assert property (p_four_upper_off)
    else $error("upper channel on in four-channel mode");
  property p_sample_after_delay;
    sample_switch |-> low_cnt_reg >= SAMS_ON_DELAY_CYC;
  endproperty
  a_sample_after_delay: assert property (p_sample_after_delay)
    else $error("sample opened before on delay");
  property p_hold_starts;
    $rose(hold_to_common) |-> ##[0:1] dac_code == 12'h800;
  endproperty
  a_hold_starts: assert property (p_hold_starts)
    else $error("conversion not started at msb trial");
  property p_hold_excl;
    hold_to_common |-> !sample_switch && converter_power;
  endproperty
  a_hold_excl: assert property (p_hold_excl)
    else $error("hold overlaps sample");
  property p_sample_long;
    $rose(hold_to_common) |-> smpl_cnt_reg >= SMPL_MIN_CYC;
  endproperty
  a_sample_long: assert property (p_sample_long)
    else $error("sample phase shorter than one and a half clocks");
  property p_done_powers_down;
    result_valid |=> !result_valid && !converter_power;
  endproperty
  a_done_powers_down: assert property (p_done_powers_down)
    else $error("power held after conversion end");
  property p_ref_follows;
    reference_load == converter_power;
  endproperty
  a_ref_follows: assert property (p_ref_follows)
    else $error("reference load differs from power");
  property p_channel_stands;
    mux_select_n [*4] |-> $stable(channel_on);
  endproperty
  a_channel_stands: assert property (p_channel_stands)
    else $error("channel changed without select fall");
endmodule
bind sams_top sams_top_sva u_sva (.sys_clk(sys_clk), .rst(rst), .sclk(sclk),
  .mux_select_n(mux_select_n), .converter_select_n(converter_select_n),
  .eight_channel(eight_channel), .channel_on(channel_on), .sample_switch(sample_switch),
  .hold_to_common(hold_to_common), .dac_code(dac_code), .converter_power(converter_power),
  .reference_load(reference_load), .data_oe(data_oe), .result_valid(result_valid));
`default_nettype wire

//--- sim/sams_host.sv
// host controller and analog comparator model facing the sequencer
// assumes sys_clk at 100 MHz; sclk made at 80 ns inside frames only
`timescale 1ns/100ps
`default_nettype none
module sams_host (
  input wire logic sys_clk,
  input wire logic data_out,
  input wire logic data_oe,
  input wire logic [11:0] dac_code,
  output logic sclk,
  output logic mux_select_n,
  output logic converter_select_n,
  output logic data_in,
  output logic comparator_high
);
  logic host_oe; // host drives the shared wire
  logic host_bit; // bit the host launches
  logic last_bit; // wire level a cycle back
  logic [11:0] vin; // input level as a code
  logic [26:1] cap; // bits seen per frame fall
  initial begin
    sclk = 1'b0;
    mux_select_n = 1'b1;
    converter_select_n = 1'b1;
    host_oe = 1'b1;
    host_bit = 1'b0;
    vin = 12'h000;
  end
  // shared wire; undriven it toggles so a stale level never passes
  always_comb begin
    data_in = data_oe ? data_out : (host_oe ? host_bit : ~last_bit);
  end
  // comparator: input code at or above trial keeps the bit
  always @(negedge sys_clk) begin
    last_bit <= data_in;
    comparator_high <= vin >= dac_code;
  end
  task automatic half;
    repeat (4) @(negedge sys_clk);
  endtask
  // one frame; without a word the mux select stays low
  task automatic frame(input logic [5:0] w, input int n, input logic [11:0] v,
                       input logic sh);
    vin = v;
    if (sh) begin
      mux_select_n = 1'b1;
      host_oe = 1'b1; // take the wire only while the selects are high
      for (int i = n - 1; i >= 0; i--) begin
        host_bit = w[i]; // launched while sclk low
        half();
        sclk = 1'b1;
        half();
        sclk = 1'b0;
      end
    end
    mux_select_n = 1'b0;
    converter_select_n = 1'b0;
    host_oe = 1'b0; // release the wire while selected
    repeat (120) @(negedge sys_clk);
    sclk = 1'b1;
    half();
    for (int k = 1; k <= 26; k++) begin
      sclk = 1'b0;
      half();
      sclk = 1'b1;
      half();
      cap[k] = data_in;
    end
    converter_select_n = 1'b1;
    sclk = 1'b0;
    half();
  endtask
endmodule
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench of the converter sequencer
// assumes the host model drives all link pins; one frame per check
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b, m) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t: %s", $time, m); end end
module testbench;
  import sams_pkg::*;
  logic sys_clk, rst, eight_channel, sclk, mux_select_n, converter_select_n;
  logic data_in, comparator_high, sample_switch, hold_to_common, converter_power;
  logic reference_load, data_out, data_oe, result_valid;
  logic [7:0] channel_on;
  logic [11:0] dac_code, result;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  sams_top u_dut (.sys_clk(sys_clk), .rst(rst), .sclk(sclk), .mux_select_n(mux_select_n),
    .converter_select_n(converter_select_n), .data_in(data_in),
    .comparator_high(comparator_high), .eight_channel(eight_channel),
    .channel_on(channel_on), .sample_switch(sample_switch), .hold_to_common(hold_to_common),
    .dac_code(dac_code), .converter_power(converter_power), .reference_load(reference_load),
    .data_out(data_out), .data_oe(data_oe), .result(result), .result_valid(result_valid));
  sams_host u_host (.sys_clk(sys_clk), .data_out(data_out), .data_oe(data_oe),
    .dac_code(dac_code), .sclk(sclk), .mux_select_n(mux_select_n),
    .converter_select_n(converter_select_n), .data_in(data_in),
    .comparator_high(comparator_high));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // cut a hang short well past the expected run length
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      $display("unexpected at %0t: timeout", $time);
      stop_test();
    end
  end
  // expected wire bit after frame fall k: two zeros, msb first, lsb copy
  function automatic logic exp_bit(input logic [11:0] v, input int k);
    if (k >= 3 && k <= 14) return v[14-k];
    if (k >= 15 && k <= 25) return v[k-14];
    return 1'b0;
  endfunction
  // the strap changes only while reset is held
  task automatic do_reset(input logic v);
    @(negedge sys_clk);
    rst = 1'b1;
    eight_channel = v;
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic check_frame(input logic [5:0] w, input int n, input logic [11:0] v,
                             input logic sh, input logic [7:0] ch);
    u_host.frame(w, n, v, sh);
    `CHK(channel_on, ch, "channel select")
    `CHK(result, v, "conversion code")
    `CHK(converter_power, 1'b0, "power after end")
    `CHK(data_oe, 1'b0, "wire released")
    for (int k = 1; k <= 26; k++) `CHK(u_host.cap[k], exp_bit(v, k), "serial bit")
  endtask
  task automatic t_eight;
    for (int c = 0; c < 8; c++) begin
      check_frame({3'h1, c[2:0]}, 4, {c[2:0], 9'h0A5}, 1'b1, 8'h01 << c);
    end
    check_frame(6'h0F, 4, 12'hFFF, 1'b1, 8'h80);
    check_frame(6'h07, 4, 12'h000, 1'b1, 8'h00);
    $display("eight-channel test done");
  endtask
  task automatic t_long;
    check_frame(6'h1E, 6, 12'h5A3, 1'b1, 8'h40);
    $display("long word test done");
  endtask
  task automatic t_separate;
    check_frame(6'h0B, 4, 12'h3C9, 1'b1, 8'h08);
    check_frame(6'h00, 0, 12'hC36, 1'b0, 8'h08);
    $display("separate select test done");
  endtask
  task automatic t_four;
    for (int a = 0; a < 8; a++) begin
      check_frame({3'h1, a[2:0]}, 4, 12'h9E1, 1'b1, a < 4 ? 8'h01 << a : 8'h00);
    end
    $display("four-channel test done");
  endtask
  initial begin
    rst = 1'b1;
    eight_channel = 1'b1;
    do_reset(1'b1);
    t_eight();
    t_long();
    t_separate();
    do_reset(1'b0);
    t_four();
    stop_test();
  end
endmodule
`default_nettype wire
